// *** status_pkg.sv ***
// Constants for the status reporting and service request block.
// Assumes a command decoder presents one-cycle operation strobes.
package status_pkg;

  // ****************************************
  // Byte layout
  // ****************************************
  localparam int BYTE_W = 8;
  localparam int SEL_W  = 3;

  // Poll byte bit positions
  localparam int POLL_SCAN_IDLE   = 0;
  localparam int POLL_EXEC_IDLE   = 1;
  localparam int POLL_FAULT_SUM   = 2;
  localparam int POLL_LOCKIN_SUM  = 3;
  localparam int POLL_OUT_PENDING = 4;
  localparam int POLL_EVENT_SUM   = 5;
  localparam int POLL_SERVICE_REQ = 6;

  // Standard event bit positions
  localparam int EV_INPUT_OVF  = 0;
  localparam int EV_OUTPUT_OVF = 2;
  localparam int EV_EXEC_FAULT = 4;
  localparam int EV_BAD_CMD    = 5;
  localparam int EV_USER_REQ   = 6;
  localparam int EV_POWER_ON   = 7;

  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] ENABLE_RST = 8'h00;

  // Register select codes for the byte and bit ports
  localparam logic [2:0] SEL_POLL   = 3'h0;
  localparam logic [2:0] SEL_EVENT  = 3'h1;
  localparam logic [2:0] SEL_LOCKIN = 3'h2;
  localparam logic [2:0] SEL_FAULT  = 3'h3;
  localparam logic [2:0] SEL_POLL_EN   = 3'h4;
  localparam logic [2:0] SEL_EVENT_EN  = 3'h5;
  localparam logic [2:0] SEL_LOCKIN_EN = 3'h6;
  localparam logic [2:0] SEL_FAULT_EN  = 3'h7;

endpackage : status_pkg

// *** status_service_request.sv ***
// Status bytes, enable registers, summaries and the service request.
// Assumes a command decoder on ref_clk_i gives one-cycle strobes;
// condition inputs from other clocks pass a 3-stage sync; event strobes are used unsynchronised.
//
// Behaviour
// [R1] Keep poll, standard event, lock-in and error status bytes.
// [R2] A status bit reads one while its event occurred or condition exists.
// [R3] Poll bit 0 is one when no scan runs; paused counts as running.
// [R4] Poll bit 1 is one when no command executes.
// [R5] Poll bits 2,3,5 are OR of status AND enable of their byte.
// [R6] Summary stays set until all enabled source bits are cleared.
// [R7] Poll bit 4 shows output buffer non-empty; bit 7 reads zero.
// [R8] Poll byte query never alters it; bits track their conditions.
// [R9] Query form bit 6 is OR of poll byte AND poll enable.
// [R10] First serial poll after a request returns bit 6 and withdraws it.
// [R11] Later polls return bit 6 zero; other bits unaffected by polls.
// [R12] Request raised only on an enabled poll bit rising zero to one.
// [R13] Many enabled source bits give one request until summary clears.
// [R14] Controller polls on request, then reads the source byte to re-arm.
// [R15] Event bit 0 on input overflow; queues are cleared.
// [R16] Event bit 2 on output overflow; queues cleared; bits 1,3 unused.
// [R17] Event bit 4 on execution fault or out-of-range parameter.
// [R18] Event bit 5 on unrecognised or illegal command.
// [R19] Event bit 6 on key or knob; bit 7 on power-on.
// [R20] Event bits are sticky until read or clear-all.
// [R21] Clear-all zeroes status bytes, leaves enable registers unchanged; code keeps bits set in the same cycle.
// [R22] Whole byte read clears all bits; single bit read clears that bit.
// [R23] Enables written whole or one bit, read whole or one bit.
// [R24] Summaries and request evaluated each cycle; edge uses previous cycle.
`timescale 1ns/1ps
module status_service_request (
  // Clock, reset, enable
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic       clk_en_i,
  // Conditions from other clock domains
  input  wire logic       scan_running_i,
  input  wire logic       exec_busy_i,
  input  wire logic       output_pending_i,
  // Standard event strobes
  input  wire logic       input_overflow_i,
  input  wire logic       output_overflow_i,
  input  wire logic       exec_fault_i,
  input  wire logic       bad_command_i,
  input  wire logic       user_request_i,
  // Lock-in and error event strobes
  input  wire logic [7:0] lockin_event_i,
  input  wire logic [7:0] fault_event_i,
  // Command strobes
  input  wire logic       clear_all_status_i,
  input  wire logic       read_byte_i,
  input  wire logic       read_bit_i,
  input  wire logic       write_byte_i,
  input  wire logic       write_bit_i,
  input  wire logic [2:0] reg_sel_i,
  input  wire logic [2:0] bit_sel_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       serial_poll_i,
  // Answers
  output logic [7:0]      rdata_o,
  output logic            rvalid_o,
  output logic [7:0]      poll_data_o,
  output logic            poll_valid_o,
  output logic            service_request_o,
  output logic            queue_clear_o
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int NSYNC     = 3;
  localparam int NCOND     = 3;
  localparam int COND_SCAN = 0;
  localparam int COND_EXEC = 1;
  localparam int COND_OUT  = 2;
  logic [NSYNC-1:0] sync_r [NCOND];
  logic [NCOND-1:0] cond_r;
  logic [NCOND-1:0] cond_raw;

  assign cond_raw = {output_pending_i, exec_busy_i, scan_running_i};

  // Elaboration checks
  generate
    if (status_pkg::BYTE_W != 8 || status_pkg::SEL_W != 3) begin : g_bad_width
      $error("status bytes must be 8 bits wide with a 3-bit select");
    end
    if (NSYNC != 3) begin : g_bad_sync
      $error("synchroniser filter is built for three stages");
    end
  endgenerate

  // Third and second stage must agree before a change counts
  generate
    for (genvar g = 0; g < NCOND; g++) begin : g_sync
      always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
          sync_r[g] <= '0;
          cond_r[g] <= 1'b0;
        end else if (clk_en_i) begin
          sync_r[g] <= {sync_r[g][NSYNC-2:0], cond_raw[g]};
          if (sync_r[g][NSYNC-1] == sync_r[g][NSYNC-2]) begin
            cond_r[g] <= sync_r[g][NSYNC-1];
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Status and enable registers
  // ****************************************
  logic [7:0] event_r;
  logic [7:0] lockin_r;
  logic [7:0] fault_r;
  logic [7:0] poll_en_r;
  logic [7:0] event_en_r;
  logic [7:0] lockin_en_r;
  logic [7:0] fault_en_r;
  logic [7:0] event_set;
  logic       power_on_r;
  logic [7:0] bit_mask;

  assign bit_mask = 8'h01 << bit_sel_i;

  always_comb begin
    event_set = 8'h00;
    event_set[status_pkg::EV_INPUT_OVF]  = input_overflow_i;   // [R15]
    event_set[status_pkg::EV_OUTPUT_OVF] = output_overflow_i;  // [R16]
    event_set[status_pkg::EV_EXEC_FAULT] = exec_fault_i;       // [R17]
    event_set[status_pkg::EV_BAD_CMD]    = bad_command_i;      // [R18]
    event_set[status_pkg::EV_USER_REQ]   = user_request_i;     // [R19]
    event_set[status_pkg::EV_POWER_ON]   = power_on_r;         // [R19]
  end

  // Clear mask for a clearable byte, set wins over clear
  function automatic logic [7:0] clr_mask(input logic [2:0] sel);
    logic [7:0] m;
    m = 8'h00;
    if (clear_all_status_i) begin
      m = 8'hFF;  // [R21]
    end else if (reg_sel_i == sel && read_byte_i) begin
      m = 8'hFF;  // [R22]
    end else if (reg_sel_i == sel && read_bit_i) begin
      m = bit_mask;  // [R22]
    end
    return m;
  endfunction : clr_mask

  // Power-on event pulse after reset
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      power_on_r <= 1'b1;
    end else if (clk_en_i) begin
      power_on_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      event_r  <= status_pkg::STATUS_RST;
      lockin_r <= status_pkg::STATUS_RST;
      fault_r  <= status_pkg::STATUS_RST;
    end else if (clk_en_i) begin
      event_r  <= (event_r  & ~clr_mask(status_pkg::SEL_EVENT))  | event_set;      // [R20]
      lockin_r <= (lockin_r & ~clr_mask(status_pkg::SEL_LOCKIN)) | lockin_event_i; // [R2]
      fault_r  <= (fault_r  & ~clr_mask(status_pkg::SEL_FAULT))  | fault_event_i;  // [R1]
    end
  end

  // Enable registers, never touched by clear-all
  logic [7:0] en_regs [4];
  assign poll_en_r   = en_regs[0];
  assign event_en_r  = en_regs[1];
  assign lockin_en_r = en_regs[2];
  assign fault_en_r  = en_regs[3];

  generate
    for (genvar e = 0; e < 4; e++) begin : g_en
      always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
          en_regs[e] <= status_pkg::ENABLE_RST;
        end else if (clk_en_i && reg_sel_i == 3'(status_pkg::SEL_POLL_EN + e)) begin
          if (write_byte_i) begin
            en_regs[e] <= wdata_i;  // [R23]
          end else if (write_bit_i) begin
            en_regs[e] <= wdata_i[0] ? (en_regs[e] | bit_mask)
                                     : (en_regs[e] & ~bit_mask);  // [R23]
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Poll byte and service request
  // ****************************************
  logic [7:0] poll_byte;
  logic       srq_query;
  logic [7:0] poll_prev_r;
  logic       srq_pend_r;
  logic       new_request;

  always_comb begin
    poll_byte = 8'h00;                                                        // [R7]
    poll_byte[status_pkg::POLL_SCAN_IDLE]   = ~cond_r[COND_SCAN];             // [R3]
    poll_byte[status_pkg::POLL_EXEC_IDLE]   = ~cond_r[COND_EXEC];             // [R4]
    poll_byte[status_pkg::POLL_FAULT_SUM]   = |(fault_r & fault_en_r);        // [R5]
    poll_byte[status_pkg::POLL_LOCKIN_SUM]  = |(lockin_r & lockin_en_r);      // [R6]
    poll_byte[status_pkg::POLL_OUT_PENDING] = cond_r[COND_OUT];               // [R7]
    poll_byte[status_pkg::POLL_EVENT_SUM]   = |(event_r & event_en_r);        // [R5]
  end

  // Query form of bit 6 ignores past polls
  assign srq_query   = |(poll_byte & poll_en_r);                              // [R9]
  // Edge on any enabled bit, so one request per rise
  assign new_request = |(poll_byte & poll_en_r & ~poll_prev_r);               // [R12] [R13]

  // Previous cycle of enabled bits for edge detection
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      poll_prev_r <= 8'h00;
    end else if (clk_en_i) begin
      poll_prev_r <= poll_byte & poll_en_r;  // [R24]
    end
  end

  // Pending request, new request wins over poll withdrawal
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      srq_pend_r <= 1'b0;
    end else if (clk_en_i) begin
      if (new_request) begin
        srq_pend_r <= 1'b1;  // [R12]
      end else if (serial_poll_i) begin
        srq_pend_r <= 1'b0;  // [R10]
      end
    end
  end

  assign service_request_o = srq_pend_r;

  // Serial poll answer
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      poll_data_o  <= 8'h00;
      poll_valid_o <= 1'b0;
    end else if (clk_en_i) begin
      poll_valid_o <= serial_poll_i;
      // Bit 6 is the pending flag sampled before withdrawal
      if (serial_poll_i) begin
        poll_data_o <= poll_byte;                                       // [R11]
        poll_data_o[status_pkg::POLL_SERVICE_REQ] <= srq_pend_r;         // [R10] [R11]
      end
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  logic [7:0] sel_val;

  always_comb begin
    case (reg_sel_i)
      status_pkg::SEL_POLL: begin
        sel_val = poll_byte;
        sel_val[status_pkg::POLL_SERVICE_REQ] = srq_query;  // [R8] [R9]
      end
      status_pkg::SEL_EVENT:     sel_val = event_r;
      status_pkg::SEL_LOCKIN:    sel_val = lockin_r;
      status_pkg::SEL_FAULT:     sel_val = fault_r;
      status_pkg::SEL_POLL_EN:   sel_val = poll_en_r;
      status_pkg::SEL_EVENT_EN:  sel_val = event_en_r;
      status_pkg::SEL_LOCKIN_EN: sel_val = lockin_en_r;
      status_pkg::SEL_FAULT_EN:  sel_val = fault_en_r;
      default:                   sel_val = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else if (clk_en_i) begin
      rvalid_o <= read_byte_i | read_bit_i;
      if (read_byte_i) begin
        rdata_o <= sel_val;                        // [R23]
      end else if (read_bit_i) begin
        rdata_o <= {7'h00, sel_val[bit_sel_i]};    // [R23]
      end
    end
  end

  // Queue flush request on either overflow
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      queue_clear_o <= 1'b0;
    end else if (clk_en_i) begin
      queue_clear_o <= input_overflow_i | output_overflow_i;  // [R15] [R16]
    end
  end

endmodule : status_service_request

// *** status_sr_checker_assertions.sv ***
// Port checker for the status and service request block.
// Bound onto every status_service_request instance.
`timescale 1ns/1ps
module status_sr_checker (
  // Clock, reset, enable
  input wire logic       ref_clk_i,
  input wire logic       reset_i,
  input wire logic       clk_en_i,
  // Strobes
  input wire logic       serial_poll_i,
  input wire logic       input_overflow_i,
  input wire logic       output_overflow_i,
  input wire logic       read_byte_i,
  input wire logic       read_bit_i,
  // Answers
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] poll_data_o,
  input wire logic       rvalid_o,
  input wire logic       poll_valid_o,
  input wire logic       service_request_o,
  input wire logic       queue_clear_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  chk_poll_answer: assert property (serial_poll_i && clk_en_i |=> poll_valid_o)
    else $error("no poll answer");
  chk_poll_srq_bit: assert property (serial_poll_i && clk_en_i && service_request_o
    |=> poll_data_o[status_pkg::POLL_SERVICE_REQ]) else $error("poll lost request bit");
  chk_srq_withdrawn: assert property (serial_poll_i && clk_en_i && service_request_o
    |=> !service_request_o) else $error("request kept after poll");
  chk_srq_holds: assert property (service_request_o && !serial_poll_i
    |=> service_request_o) else $error("request dropped unpolled");
  chk_unused_bit: assert property (poll_valid_o |-> !poll_data_o[7])
    else $error("poll bit 7 set");
  chk_read_answer: assert property (
    (read_byte_i || read_bit_i) && clk_en_i |=> rvalid_o) else $error("no read answer");
  chk_bit_read: assert property (read_bit_i && !read_byte_i && clk_en_i
    |=> rdata_o[7:1] == 7'h00) else $error("bit read upper bits set");
  chk_queue_clear: assert property (
    (input_overflow_i || output_overflow_i) && clk_en_i |=> queue_clear_o)
    else $error("queues not cleared");
  chk_rvalid_pulse: assert property (
    !read_byte_i && !read_bit_i && clk_en_i |=> !rvalid_o) else $error("read answer unasked");
  chk_poll_data_hold: assert property (
    !serial_poll_i && clk_en_i |=> $stable(poll_data_o)) else $error("poll answer moved");
  chk_freeze_state: assert property (!clk_en_i
    |=> $stable(service_request_o) && $stable(rdata_o) && $stable(rvalid_o)
        && $stable(queue_clear_o)) else $error("state moved while frozen");
endmodule : status_sr_checker
bind status_service_request status_sr_checker status_sr_checker_inst (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .serial_poll_i(serial_poll_i),
  .input_overflow_i(input_overflow_i), .output_overflow_i(output_overflow_i),
  .read_byte_i(read_byte_i), .read_bit_i(read_bit_i), .rdata_o(rdata_o),
  .poll_data_o(poll_data_o), .rvalid_o(rvalid_o), .poll_valid_o(poll_valid_o),
  .service_request_o(service_request_o), .queue_clear_o(queue_clear_o));

// *** poll_controller.sv ***
// Remote controller model: serial polls a pending request.
// Assumes the block's clock; acts on falling edges.
`timescale 1ns/1ps
module poll_controller (
  // Clock
  input  wire logic       ref_clk_i,
  // Request and test controls
  input  wire logic       srq_i,
  input  wire logic       force_i,
  input  wire logic [3:0] lag_i,
  // Poll strobe and count
  output logic            poll_o,
  output logic [7:0]      n_polls_o
);
  logic       poll_r    = 1'b0;
  logic [3:0] wait_r    = 4'h0;
  logic [7:0] n_polls_r = 8'h00;

  assign poll_o    = poll_r;
  assign n_polls_o = n_polls_r;

  // Polls once the request has stood lag_i cycles, or on demand
  always @(negedge ref_clk_i) begin
    if (force_i || (srq_i && !poll_r && wait_r == lag_i)) begin
      poll_r    <= 1'b1;
      wait_r    <= 4'h0;
      n_polls_r <= n_polls_r + 8'h01;
    end else begin
      poll_r <= 1'b0;
      if (srq_i && !poll_r) begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule : poll_controller

// *** status_service_request_test.sv ***
// Testbench for status_service_request with a polling controller.
// Assumes status_pkg, checker and controller model compiled first.
`timescale 1ns/1ps
module status_service_request_test;
  logic       ref_clk_i, reset_i, clk_en_i, scan_running_i, exec_busy_i, output_pending_i;
  logic       clear_all_status_i, read_byte_i, read_bit_i, write_byte_i, write_bit_i;
  logic       rvalid_o, poll_valid_o, service_request_o, queue_clear_o, serial_poll_i, force_r;
  logic [4:0] ev_r;
  logic [3:0] lag_r;
  logic [2:0] reg_sel_i, bit_sel_i;
  logic [7:0] wdata_i, lockin_event_i, fault_event_i, rdata_o, poll_data_o, polls;
  int         n_mismatch = 0;
  int         check_count = 0;
  status_service_request status_service_request_inst (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .scan_running_i(scan_running_i), .exec_busy_i(exec_busy_i),
    .output_pending_i(output_pending_i), .input_overflow_i(ev_r[0]),
    .output_overflow_i(ev_r[1]), .exec_fault_i(ev_r[2]), .bad_command_i(ev_r[3]),
    .user_request_i(ev_r[4]), .lockin_event_i(lockin_event_i),
    .fault_event_i(fault_event_i), .clear_all_status_i(clear_all_status_i),
    .read_byte_i(read_byte_i), .read_bit_i(read_bit_i), .write_byte_i(write_byte_i),
    .write_bit_i(write_bit_i), .reg_sel_i(reg_sel_i), .bit_sel_i(bit_sel_i),
    .wdata_i(wdata_i), .serial_poll_i(serial_poll_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .poll_data_o(poll_data_o), .poll_valid_o(poll_valid_o),
    .service_request_o(service_request_o), .queue_clear_o(queue_clear_o));
  poll_controller poll_controller_inst (.ref_clk_i(ref_clk_i), .srq_i(service_request_o),
    .force_i(force_r), .lag_i(lag_r), .poll_o(serial_poll_i), .n_polls_o(polls));
  task automatic finish_test;
    if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rdc(input logic [2:0] s, b, input logic one, input logic [7:0] exp);
    int i;
    @(negedge ref_clk_i);
    reg_sel_i <= s;
    bit_sel_i <= b;
    read_bit_i <= one;
    read_byte_i <= !one;
    @(negedge ref_clk_i);
    read_bit_i <= 1'b0;
    read_byte_i <= 1'b0;
    for (i = 0; i < 3 && rvalid_o !== 1'b1; i++) @(negedge ref_clk_i);
    check({7'h00, rvalid_o}, 8'h01);
    if (rvalid_o !== 1'b1) finish_test();
    check(rdata_o, exp);
  endtask : rdc
  task automatic wr(input logic [2:0] s, b, input logic one, input logic [7:0] d);
    @(negedge ref_clk_i);
    reg_sel_i <= s;
    bit_sel_i <= b;
    wdata_i <= d;
    write_bit_i <= one;
    write_byte_i <= !one;
    @(negedge ref_clk_i);
    write_bit_i <= 1'b0;
    write_byte_i <= 1'b0;
  endtask : wr
  task automatic pulse(input logic [4:0] e, input logic [7:0] l, f, input logic clr);
    @(negedge ref_clk_i);
    ev_r <= e;
    lockin_event_i <= l;
    fault_event_i <= f;
    clear_all_status_i <= clr;
    @(negedge ref_clk_i);
    ev_r <= 5'h00;
    lockin_event_i <= 8'h00;
    fault_event_i <= 8'h00;
    clear_all_status_i <= 1'b0;
  endtask : pulse
  task automatic await_poll(input logic [7:0] k, input logic [7:0] exp);
    int i;
    for (i = 0; i < 20 && polls !== k; i++) @(negedge ref_clk_i);
    check(polls, k);
    if (polls !== k) finish_test();
    check({7'h00, poll_valid_o}, 8'h01);
    check(poll_data_o, exp);
  endtask : await_poll
  task automatic s_reset;
    repeat (6) @(negedge ref_clk_i);
    rdc(status_pkg::SEL_EVENT, 3'h0, 1'b0, 8'h80);
    rdc(status_pkg::SEL_EVENT, 3'h0, 1'b0, 8'h00);
    rdc(status_pkg::SEL_POLL, 3'h0, 1'b0, 8'h03);
  endtask : s_reset
  task automatic s_events;
    pulse(5'h1f, 8'h00, 8'h81, 1'b0);
    check({7'h00, queue_clear_o}, 8'h01);
    rdc(status_pkg::SEL_EVENT, 3'h4, 1'b1, 8'h01);
    rdc(status_pkg::SEL_EVENT, 3'h0, 1'b0, 8'h65);
    rdc(status_pkg::SEL_FAULT, 3'h0, 1'b0, 8'h81);
    pulse(5'h1f, 8'h10, 8'h00, 1'b0);
    pulse(5'h00, 8'h00, 8'h00, 1'b1);
    rdc(status_pkg::SEL_EVENT, 3'h0, 1'b0, 8'h00);
    rdc(status_pkg::SEL_LOCKIN, 3'h0, 1'b0, 8'h00);
    pulse(5'h04, 8'h00, 8'h00, 1'b1);
    rdc(status_pkg::SEL_EVENT, 3'h0, 1'b0, 8'h10);
  endtask : s_events
  task automatic s_enables;
    wr(status_pkg::SEL_EVENT_EN, 3'h0, 1'b0, 8'ha5);
    wr(status_pkg::SEL_EVENT_EN, 3'h1, 1'b1, 8'h01);
    wr(status_pkg::SEL_POLL, 3'h0, 1'b0, 8'hff);
    pulse(5'h00, 8'h00, 8'h00, 1'b1);
    rdc(status_pkg::SEL_EVENT_EN, 3'h0, 1'b0, 8'ha7);
    rdc(status_pkg::SEL_EVENT_EN, 3'h2, 1'b1, 8'h01);
    rdc(status_pkg::SEL_POLL, 3'h0, 1'b0, 8'h03);
    wr(status_pkg::SEL_EVENT_EN, 3'h0, 1'b0, 8'h00);
  endtask : s_enables
  task automatic s_levels;
    scan_running_i <= 1'b1;
    exec_busy_i <= 1'b1;
    output_pending_i <= 1'b1;
    repeat (6) @(negedge ref_clk_i);
    rdc(status_pkg::SEL_POLL, 3'h0, 1'b0, 8'h10);
    scan_running_i <= 1'b0;
    exec_busy_i <= 1'b0;
    output_pending_i <= 1'b0;
    repeat (6) @(negedge ref_clk_i);
    rdc(status_pkg::SEL_POLL, 3'h0, 1'b0, 8'h03);
  endtask : s_levels
  task automatic s_srq;
    lag_r <= 4'h3;
    wr(status_pkg::SEL_LOCKIN_EN, 3'h0, 1'b1, 8'h01);
    wr(status_pkg::SEL_POLL_EN, 3'h3, 1'b1, 8'h01);
    pulse(5'h00, 8'h01, 8'h00, 1'b0);
    await_poll(8'h01, 8'h4b);
    pulse(5'h00, 8'h03, 8'h00, 1'b0);
    repeat (4) @(negedge ref_clk_i);
    check({7'h00, service_request_o}, 8'h00);
    rdc(status_pkg::SEL_POLL, 3'h0, 1'b0, 8'h4b);
    force_r <= 1'b1;
    @(negedge ref_clk_i);
    force_r <= 1'b0;
    await_poll(8'h02, 8'h0b);
    rdc(status_pkg::SEL_LOCKIN, 3'h0, 1'b0, 8'h03);
    lag_r <= 4'h0;
    pulse(5'h00, 8'h01, 8'h00, 1'b0);
    await_poll(8'h03, 8'h4b);
    rdc(status_pkg::SEL_LOCKIN, 3'h0, 1'b0, 8'h01);
  endtask : s_srq
  task automatic s_rereset;
    @(negedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (3) @(negedge ref_clk_i);
    reset_i <= 1'b0;
    check({7'h00, service_request_o}, 8'h00);
    rdc(status_pkg::SEL_EVENT, 3'h0, 1'b0, 8'h80);
  endtask : s_rereset
  task automatic s_freeze;
    @(negedge ref_clk_i);
    clk_en_i <= 1'b0;
    ev_r <= 5'h04;
    @(negedge ref_clk_i);
    ev_r <= 5'h00;
    clk_en_i <= 1'b1;
    rdc(status_pkg::SEL_EVENT, 3'h0, 1'b0, 8'h00);
    pulse(5'h04, 8'h00, 8'h00, 1'b0);
    rdc(status_pkg::SEL_EVENT, 3'h0, 1'b0, 8'h10);
  endtask : s_freeze
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    {reset_i, clk_en_i} = 2'b11;
    {scan_running_i, exec_busy_i, output_pending_i, force_r} = 4'h0;
    {clear_all_status_i, read_byte_i, read_bit_i, write_byte_i, write_bit_i} = 5'h00;
    {ev_r, lag_r, reg_sel_i, bit_sel_i} = 15'h0000;
    {wdata_i, lockin_event_i, fault_event_i} = 24'h00_0000;
    repeat (10) @(negedge ref_clk_i);
    reset_i <= 1'b0;
    s_reset();
    s_events();
    s_enables();
    s_levels();
    s_srq();
    s_rereset();
    s_freeze();
    finish_test();
  end
endmodule : status_service_request_test
